//--- verilog/bpc_pkg.sv
// ---------------------------------------------------------------
// Bus geometry and register map.
// ---------------------------------------------------------------
package bpc_pkg;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  BLK_EN_OFF = 8'h00;
  localparam logic [7:0]  CTL_OFF    = 8'h10;
  localparam logic        BLK_EN_RST = 1'h1;
  localparam int          BLK_EN_BIT = 31;

  // ---------------------------------------------------------------
  // Control word, indexed by field number (0 sits at bus bit 31).
  // ---------------------------------------------------------------
  localparam int          CTL_W      = 13;
  localparam logic [12:0] CTL_RST    = 13'h1f7e;
  localparam int          F_LOOP     = 0;
  localparam int          F_DUPLEX   = 1;
  localparam int          F_SQE      = 2;
  localparam int          F_LED      = 3;
  localparam int          F_SHARE    = 4;
  localparam int          F_USB_RATE = 5;
  localparam int          F_USB_PWR  = 6;
  localparam int          F_SPARE    = 7;
  localparam int          F_VID_LED  = 8;
  localparam int          F_VID_CLK  = 9;
  localparam int          F_VID_RST  = 10;
  localparam int          F_MODEM    = 11;
  localparam int          F_MFUNC    = 12;

  // ---------------------------------------------------------------
  // Daughter board kinds as strapped on the board type input.
  // ---------------------------------------------------------------
  localparam logic [2:0]  DBK_NONE      = 3'h0;
  localparam logic [2:0]  DBK_USB_VIDEO = 3'h1;
  localparam logic [2:0]  DBK_USB       = 3'h2;
  localparam logic [2:0]  DBK_CELL      = 3'h3;
  localparam logic [2:0]  DBK_FAST_ETH  = 3'h4;

  // ---------------------------------------------------------------
  // Bus slave states.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BPC_IDLE = 2'h1,
    BPC_ACC  = 2'h2
  } bpc_apb_st_t;
endpackage

//--- verilog/bpc_apb_if.sv
`timescale 1ns/100ps
module bpc_apb_if (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rstn,
  // Bus handshake.
  input  wire logic psel,
  input  wire logic penable,
  input  wire logic pwrite,
  output logic      pready,
  // Strobes to the register file.
  output logic      setup_stb,
  output logic      wr_stb
);
  import bpc_pkg::*;

  bpc_apb_st_t state_r;
  bpc_apb_st_t state_nxt;

  // Every transfer answers in its first access cycle, no wait states.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BPC_IDLE: begin
        if (psel && !penable) begin
          state_nxt = BPC_ACC;
        end
      end
      BPC_ACC: begin
        if (psel && penable) begin
          state_nxt = BPC_IDLE;
        end
      end
      default: begin
        state_nxt = BPC_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= BPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Strobes; a write lands only on the edge that completes it.
  assign pready    = (state_r == BPC_ACC);
  assign setup_stb = (state_r == BPC_IDLE) && psel && !penable;
  assign wr_stb    = (state_r == BPC_ACC) && psel && penable && pwrite;
endmodule

//--- verilog/bpc_fall_det.sv
`timescale 1ns/100ps
module bpc_fall_det (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rstn,
  // Watched level and its falling-edge pulse.
  input  wire logic level,
  output logic      fall
);
  import bpc_pkg::*;

  logic prev_r;

  // The level idles high, so the history resets high to avoid a
  // false edge at reset release.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= 1'h1;
      fall   <= 1'h0;
    end else begin
      prev_r <= level;
      fall   <= prev_r && !level;
    end
  end
endmodule

//--- verilog/bpc_ctl.sv
// Behaviour
// R1: Field 0 high selects Ethernet loop-back.
// R2: Field 1 low selects full duplex.
// R3: Field 2 low starts simulated collision test.
// R4: Field 3 low lights user lamp.
// R5: Field 4 low enables board-dependent shared port.
// R6: Field 5 high means USB full speed.
// R7: Field 6 low switches USB power on.
// R8: Field 8 low lights video activity lamp.
// R9: Field 9 high enables video clock oscillator.
// R10: Software enables video clock only when safe.
// R11: Field 10 falling edge resets video encoder.
// R12: Field 11 low enables modem on video board.
// R13: Field 12 high selects modem data function.
// R14: Access works only while block enabled.
// R15: Register decoded at offset 0x10, accessible while block enabled.
// R16: Defaults at reset; levels shown on connectors.
// R17: Field 7 read-write; fields 13-31 ignored.
// R18: Field 0 is bus bit 31.
`timescale 1ns/100ps
module bpc_ctl (
  // Clock and reset.
  input  wire logic                       CLK,
  input  wire logic                       RSTN,
  // Register bus.
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [bpc_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [bpc_pkg::DATA_W-1:0] PWDATA,
  output logic                            PREADY,
  output logic [bpc_pkg::DATA_W-1:0]      PRDATA,
  output logic                            PSLVERR,
  // Fitted daughter board kind.
  input  wire logic [2:0]                 DB_KIND,
  // Ethernet transceiver.
  output logic                            ETH_LOOPBACK,
  output logic                            ETH_FULL_DUPLEX_N,
  output logic                            SQE_TEST_ENABLE_N,
  // User lamp.
  output logic                            USER_LED_N,
  // Shared port enables.
  output logic                            USB_XCVR_ENABLE_N,
  output logic                            CELL_PORT_ENABLE_N,
  output logic                            FAST_ETHERNET_PORT_ENABLE_N,
  // USB port.
  output logic                            USB_RATE_SELECT,
  output logic                            USB_POWER_ENABLE_N,
  // Video.
  output logic                            VIDEO_ACTIVITY_LED_N,
  output logic                            VIDEO_CLOCK_SOURCE_ENABLE,
  output logic                            VIDEO_ENCODER_RESET_N,
  output logic                            VIDEO_ENCODER_RESET_FALL,
  // Modem tool.
  output logic                            MODEM_TOOL_ENABLE_N,
  output logic                            MODEM_FUNCTION_SELECT,
  // Raw levels towards the connectors.
  output logic [bpc_pkg::CTL_W-1:0]       CONN_LEVELS
);
  import bpc_pkg::*;

  // ---------------------------------------------------------------
  // Storage and decode.
  // ---------------------------------------------------------------
  logic              setup_stb;
  logic              wr_stb;
  logic              blk_en_r;
  logic [CTL_W-1:0]  ctl_r;
  logic [CTL_W-1:0]  ctl_nxt;
  logic [CTL_W-1:0]  wr_map;
  logic [DATA_W-1:0] ctl_word;
  logic [DATA_W-1:0] rd_word;
  logic              hit_ctl;
  logic              hit_en;
  logic              rd_err;
  logic              wr_ctl;
  logic              wr_en;

  // Bus handshake and strobes.
  bpc_apb_if u_apb (
    .clk       (CLK),
    .rstn      (RSTN),
    .psel      (PSEL),
    .penable   (PENABLE),
    .pwrite    (PWRITE),
    .pready    (PREADY),
    .setup_stb (setup_stb),
    .wr_stb    (wr_stb)
  );

  // Field n sits at bus bit 31-n in both directions.
  for (genvar i = 0; i < CTL_W; i++) begin : g_map
    assign wr_map[i]          = PWDATA[DATA_W-1-i]; // R18
    assign ctl_word[DATA_W-1-i] = ctl_r[i]; // R18
  end
  // Fields 13 to 31 have no storage and read as zero.
  assign ctl_word[DATA_W-CTL_W-1:0] = '0; // R17

  // The enable register stays reachable, else the block is locked out.
  assign hit_en  = (PADDR == BLK_EN_OFF);
  assign hit_ctl = (PADDR == CTL_OFF) && blk_en_r; // R14 R15
  assign rd_err  = !(hit_en || hit_ctl); // R14
  assign wr_ctl  = wr_stb && hit_ctl; // R14
  assign wr_en   = wr_stb && hit_en;

  // Read word chosen by address.
  always_comb begin
    rd_word = '0;
    if (hit_ctl) begin
      rd_word = ctl_word; // R15
    end else if (hit_en) begin
      rd_word[BLK_EN_BIT] = blk_en_r;
    end
  end

  // Next control word; unaddressed or disabled writes keep it.
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt = wr_map; // R17
    end
  end

  // Control word with its power-on defaults.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_r <= CTL_RST; // R16
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // Block enable, an own register at the base of the window.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      blk_en_r <= BLK_EN_RST;
    end else if (wr_en) begin
      blk_en_r <= PWDATA[BLK_EN_BIT];
    end
  end

  // Read data and error are caught in the setup cycle so they stand
  // from flip-flops through the access cycle.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA  <= '0;
      PSLVERR <= 1'h0;
    end else if (setup_stb) begin
      PRDATA  <= rd_word;
      PSLVERR <= rd_err; // R14
    end
  end

  // ---------------------------------------------------------------
  // Peripheral control lines.
  // ---------------------------------------------------------------
  assign ETH_LOOPBACK      = ctl_r[F_LOOP]; // R1
  assign ETH_FULL_DUPLEX_N = ctl_r[F_DUPLEX]; // R2
  assign SQE_TEST_ENABLE_N = ctl_r[F_SQE]; // R3
  assign USER_LED_N        = ctl_r[F_LED]; // R4
  assign USB_RATE_SELECT   = ctl_r[F_USB_RATE]; // R6
  assign USB_POWER_ENABLE_N = ctl_r[F_USB_PWR]; // R7
  assign VIDEO_ACTIVITY_LED_N = ctl_r[F_VID_LED]; // R8
  // Software must prepare the processor first; nothing here blocks it.
  assign VIDEO_CLOCK_SOURCE_ENABLE = ctl_r[F_VID_CLK]; // R9
  assign VIDEO_ENCODER_RESET_N = ctl_r[F_VID_RST]; // R11
  assign MODEM_FUNCTION_SELECT = ctl_r[F_MFUNC]; // R13
  assign CONN_LEVELS       = ctl_r; // R16

  // The shared enable reaches only the port of the fitted board; the
  // others stay inactive so a wrong board never sees a stray enable.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      USB_XCVR_ENABLE_N           <= 1'h1;
      CELL_PORT_ENABLE_N          <= 1'h1;
      FAST_ETHERNET_PORT_ENABLE_N <= 1'h1;
    end else begin
      USB_XCVR_ENABLE_N <= ((DB_KIND == DBK_USB_VIDEO) ||
                            (DB_KIND == DBK_USB)) ?
                           ctl_r[F_SHARE] : 1'h1; // R5
      CELL_PORT_ENABLE_N <= (DB_KIND == DBK_CELL) ?
                            ctl_r[F_SHARE] : 1'h1; // R5
      FAST_ETHERNET_PORT_ENABLE_N <= (DB_KIND == DBK_FAST_ETH) ?
                                     ctl_r[F_SHARE] : 1'h1; // R5
    end
  end

  // The modem tool runs only beside the video-capable board.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MODEM_TOOL_ENABLE_N <= 1'h1;
    end else begin
      MODEM_TOOL_ENABLE_N <= (DB_KIND == DBK_USB_VIDEO) ?
                             ctl_r[F_MODEM] : 1'h1; // R12
    end
  end

  // The encoder reacts to the falling edge, so that edge is also
  // given as a pulse for logic that cannot watch a level.
  bpc_fall_det u_vid_fall (
    .clk   (CLK),
    .rstn  (RSTN),
    .level (ctl_r[F_VID_RST]),
    .fall  (VIDEO_ENCODER_RESET_FALL)
  );

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  bus_answer_a: assert property ( // R15
    (PSEL && !PENABLE && PREADY == 1'h0) |=> PREADY)
    else $error("Access phase not answered at once.");

  ctl_write_a: assert property ( // R15
    wr_ctl |=> (ctl_r == $past(wr_map)))
    else $error("Control word did not take the write.");

  blocked_write_a: assert property ( // R14
    (wr_stb && (PADDR == CTL_OFF) && !blk_en_r) |=> $stable(ctl_r))
    else $error("Write landed while the block was disabled.");

  blocked_err_a: assert property ( // R14
    (setup_stb && (PADDR == CTL_OFF) && !blk_en_r) |=>
      (PSLVERR && PREADY))
    else $error("Disabled access not flagged.");

  enable_write_a: assert property ( // R14
    wr_en |=> (blk_en_r == $past(PWDATA[BLK_EN_BIT])))
    else $error("Block enable did not take the write.");

  idle_hold_a: assert property ( // R15
    !wr_ctl |=> $stable(ctl_r))
    else $error("Control word changed without an accepted write.");

  err_clear_a: assert property ( // R15
    (setup_stb && hit_ctl) |=> !PSLVERR)
    else $error("Accepted access flagged as an error.");

  spare_hold_a: assert property ( // R17
    wr_ctl |=> (ctl_r[F_SPARE] == $past(PWDATA[DATA_W-1-F_SPARE])))
    else $error("Spare field did not take the write.");

  loop_bit_a: assert property ( // R1
    wr_ctl |=> (ETH_LOOPBACK == $past(PWDATA[31])))
    else $error("Loop-back line does not follow bus bit 31.");

  duplex_bit_a: assert property ( // R2
    wr_ctl |=> (ETH_FULL_DUPLEX_N == $past(PWDATA[30])))
    else $error("Duplex line does not follow bus bit 30.");

  sqe_bit_a: assert property ( // R3
    wr_ctl |=> (SQE_TEST_ENABLE_N == $past(PWDATA[29])))
    else $error("Collision test line does not follow bus bit 29.");

  user_led_a: assert property ( // R4
    wr_ctl |=> (USER_LED_N == $past(PWDATA[28])))
    else $error("User lamp does not follow bus bit 28.");

  share_gate_a: assert property ( // R5
    ((DB_KIND != DBK_USB_VIDEO) && (DB_KIND != DBK_USB)) |=>
      USB_XCVR_ENABLE_N)
    else $error("USB transceiver enabled on a board without USB.");

  share_pass_a: assert property ( // R5
    (DB_KIND == DBK_CELL) |=>
      (CELL_PORT_ENABLE_N == $past(ctl_r[F_SHARE])))
    else $error("Cell-bus enable does not follow field 4.");

  usb_pass_a: assert property ( // R5
    ((DB_KIND == DBK_USB_VIDEO) || (DB_KIND == DBK_USB)) |=>
      (USB_XCVR_ENABLE_N == $past(ctl_r[F_SHARE])))
    else $error("USB transceiver enable does not follow field 4.");

  cell_gate_a: assert property ( // R5
    (DB_KIND != DBK_CELL) |=> CELL_PORT_ENABLE_N)
    else $error("Cell-bus port enabled on another board.");

  fast_gate_a: assert property ( // R5
    (DB_KIND != DBK_FAST_ETH) |=> FAST_ETHERNET_PORT_ENABLE_N)
    else $error("Fast Ethernet port enabled on another board.");

  fast_pass_a: assert property ( // R5
    (DB_KIND == DBK_FAST_ETH) |=>
      (FAST_ETHERNET_PORT_ENABLE_N == $past(ctl_r[F_SHARE])))
    else $error("Fast Ethernet enable does not follow field 4.");

  usb_rate_a: assert property ( // R6
    wr_ctl |=> (USB_RATE_SELECT == $past(PWDATA[26])))
    else $error("USB rate does not follow bus bit 26.");

  usb_power_a: assert property ( // R7
    wr_ctl |=> (USB_POWER_ENABLE_N == $past(PWDATA[25])))
    else $error("USB power does not follow bus bit 25.");

  video_led_a: assert property ( // R8
    wr_ctl |=> (VIDEO_ACTIVITY_LED_N == $past(PWDATA[23])))
    else $error("Video lamp does not follow bus bit 23.");

  video_clock_a: assert property ( // R9
    wr_ctl |=> (VIDEO_CLOCK_SOURCE_ENABLE == $past(PWDATA[22])))
    else $error("Video clock enable does not follow bus bit 22.");

  encoder_fall_a: assert property ( // R11
    $fell(VIDEO_ENCODER_RESET_N) |=> VIDEO_ENCODER_RESET_FALL ##1
      !VIDEO_ENCODER_RESET_FALL)
    else $error("Encoder reset edge pulse missing or too long.");

  fall_only_a: assert property ( // R11
    VIDEO_ENCODER_RESET_FALL |->
      ($past(VIDEO_ENCODER_RESET_N, 2) && !$past(VIDEO_ENCODER_RESET_N)))
    else $error("Encoder reset pulse without a falling edge.");

  modem_gate_a: assert property ( // R12
    (DB_KIND != DBK_USB_VIDEO) |=> MODEM_TOOL_ENABLE_N)
    else $error("Modem enabled without the matching board.");

  modem_pass_a: assert property ( // R12
    (DB_KIND == DBK_USB_VIDEO) |=>
      (MODEM_TOOL_ENABLE_N == $past(ctl_r[F_MODEM])))
    else $error("Modem enable does not follow field 11.");

  modem_func_a: assert property ( // R13
    wr_ctl |=> (MODEM_FUNCTION_SELECT == $past(PWDATA[19])))
    else $error("Modem function does not follow bus bit 19.");

  conn_level_a: assert property ( // R16
    (CONN_LEVELS == ctl_r) && (CONN_LEVELS[F_LOOP] == ETH_LOOPBACK))
    else $error("Connector levels differ from the control word.");

  read_back_a: assert property ( // R17
    (setup_stb && hit_ctl) |=>
      ((PRDATA[DATA_W-CTL_W-1:0] == '0) &&
       (PRDATA[DATA_W-1-F_SPARE] == ctl_r[F_SPARE])))
    else $error("Read of control word malformed.");

  read_order_a: assert property ( // R18
    (setup_stb && hit_ctl) |=>
      (PRDATA[DATA_W-1] == ctl_r[F_LOOP]) &&
      (PRDATA[DATA_W-1-F_MFUNC] == ctl_r[F_MFUNC]))
    else $error("Field order on the bus is wrong.");

  wr_ctl_c: cover property (wr_ctl);
  wr_blocked_c: cover property (wr_stb && !blk_en_r);
  rd_ctl_c: cover property (setup_stb && hit_ctl && !PWRITE);
  enc_fall_c: cover property (VIDEO_ENCODER_RESET_FALL);
  share_on_c: cover property (!USB_XCVR_ENABLE_N || !CELL_PORT_ENABLE_N ||
    !FAST_ETHERNET_PORT_ENABLE_N);
endmodule

//--- verif/bpc_board_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Peripherals behind the control lines: video encoder and clock.
// ---------------------------------------------------------------
module bpc_board_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rstn,
  // Encoder reset line, its edge pulse and the video clock source.
  input  wire logic enc_rst_n,
  input  wire logic enc_fall,
  input  wire logic clk_en,
  input  wire logic clk_ok,
  // Event counts for the bench.
  output int        resets,
  output int        pulses,
  output int        hazards
);
  logic line_q;

  // The encoder resets on a falling edge only, so a held low is one reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_q  <= 1'h1;
      resets  <= 0;
      pulses  <= 0;
      hazards <= 0;
    end else begin
      line_q <= enc_rst_n;
      if (line_q && !enc_rst_n) begin
        resets <= resets + 1;
      end
      if (enc_fall) begin
        pulses <= pulses + 1;
      end
      // A clock driving an unprepared processor could damage it.
      if (clk_en && !clk_ok) begin
        hazards <= hazards + 1;
      end
    end
  end
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import bpc_pkg::*;

  // ---------------------------------------------------------------
  // Stimulus, observed lines and expected state.
  // ---------------------------------------------------------------
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [2:0]  db_kind;
  logic        clk_ok;
  wire         pready;
  wire         pslverr;
  wire  [31:0] prdata;
  wire  [13:0] pins;
  wire  [12:0] conn;
  wire         vid_fall;
  int          resets;
  int          pulses;
  int          hazards;
  int          n_fail;
  int          comparisons;
  int          nfall;
  logic [12:0] exp_w;
  logic        exp_en;
  logic [31:0] seed = 32'h48;
  logic [7:0]  bad [5] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'hfc};

  bpc_ctl dut (
    .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .DB_KIND(db_kind),
    .ETH_LOOPBACK(pins[13]), .ETH_FULL_DUPLEX_N(pins[12]),
    .SQE_TEST_ENABLE_N(pins[11]), .USER_LED_N(pins[10]),
    .USB_RATE_SELECT(pins[9]), .USB_POWER_ENABLE_N(pins[8]),
    .VIDEO_ACTIVITY_LED_N(pins[7]), .VIDEO_CLOCK_SOURCE_ENABLE(pins[6]),
    .VIDEO_ENCODER_RESET_N(pins[5]), .MODEM_FUNCTION_SELECT(pins[4]),
    .USB_XCVR_ENABLE_N(pins[3]), .CELL_PORT_ENABLE_N(pins[2]),
    .FAST_ETHERNET_PORT_ENABLE_N(pins[1]), .MODEM_TOOL_ENABLE_N(pins[0]),
    .VIDEO_ENCODER_RESET_FALL(vid_fall), .CONN_LEVELS(conn)
  );

  bpc_board_model board (
    .clk(clk), .rstn(rstn), .enc_rst_n(pins[5]), .enc_fall(vid_fall),
    .clk_en(pins[6]), .clk_ok(clk_ok), .resets(resets),
    .pulses(pulses), .hazards(hazards)
  );

  // ---------------------------------------------------------------
  // Expectation helpers.
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Field n travels on bus bit 31-n; the low bits carry nothing.
  function automatic logic [31:0] to_bus(logic [12:0] w);
    logic [31:0] b;
    b = 32'h0;
    for (int i = 0; i < CTL_W; i++) begin
      b[31-i] = w[i];
    end
    return b;
  endfunction

  function automatic logic [12:0] from_bus(logic [31:0] d);
    logic [12:0] w;
    for (int i = 0; i < CTL_W; i++) begin
      w[i] = d[31-i];
    end
    return w;
  endfunction

  // Shared enables are forced off unless the fitted board uses them.
  function automatic logic [13:0] exp_pins(logic [12:0] w, logic [2:0] k);
    return {w[0], w[1], w[2], w[3], w[5], w[6], w[8], w[9], w[10], w[12],
            w[4] | !(k == DBK_USB_VIDEO || k == DBK_USB),
            w[4] | (k != DBK_CELL), w[4] | (k != DBK_FAST_ETH),
            w[11] | (k != DBK_USB_VIDEO)};
  endfunction

  // ---------------------------------------------------------------
  // Compare, bus and closing tasks.
  // ---------------------------------------------------------------
  // Every compare task ends here: count it and report a mismatch.
  task automatic tally(input logic bad, input string what);
    comparisons++;
    if (bad) begin
      n_fail++;
      $display("ERROR %0t: %s", $time, what);
    end
  endtask

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    tally(got !== exp, $sformatf("read %h, expected %h", got, exp));
  endtask

  task automatic cmp_err(input logic got, input logic exp);
    tally(got !== exp, $sformatf("error flag %b, expected %b", got, exp));
  endtask

  task automatic cmp_pins(input logic [13:0] got, input logic [13:0] exp);
    tally(got !== exp, $sformatf("lines %h, expected %h", got, exp));
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    tally(got != exp, $sformatf("count %0d, expected %0d", got, exp));
  endtask

  task automatic finish_test;
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One transfer; the request stands until pready is seen high at a
  // rising edge, and the answer is taken at that same edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      n_fail++;
      finish_test();
    end
  endtask

  // Access with expectations from the bench's own copy of the registers.
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    logic        ok;
    logic [12:0] nw;
    logic [31:0] ex;
    ok = (a == BLK_EN_OFF) || (a == CTL_OFF && exp_en);
    ex = (a == CTL_OFF) ? to_bus(exp_w) : {exp_en, 31'h0};
    apb(w, a, d, rd, er);
    cmp_err(er, !ok);
    if (!w) begin
      cmp_data(rd, ok ? ex : 32'h0);
    end else if (ok && a == CTL_OFF) begin
      nw = from_bus(d);
      if (exp_w[F_VID_RST] && !nw[F_VID_RST]) begin
        nfall++;
      end
      exp_w = nw;
    end else if (ok) begin
      exp_en = d[BLK_EN_BIT];
    end
  endtask

  task automatic check_pins;
    logic [13:0] ep;
    repeat (3) @(posedge clk);
    @(negedge clk);
    ep = exp_pins(exp_w, db_kind);
    cmp_pins(pins, ep);
    cmp_pins({1'h0, conn}, {1'h0, exp_w});
    cmp_cnt(resets, nfall);
    cmp_cnt(pulses, nfall);
    cmp_cnt(hazards, 0);
  endtask

  // ---------------------------------------------------------------
  // Clock and main sequence.
  // ---------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, db_kind} = '0;
    rstn   = 1'h0;
    clk_ok = 1'h1;
    exp_w  = CTL_RST;
    exp_en = 1'h1;
    nfall  = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    // Defaults, seen under every board kind.
    access(1'h0, CTL_OFF, 32'h0);
    access(1'h0, BLK_EN_OFF, 32'h0);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      db_kind <= 3'(k);
      check_pins();
    end
    // Extremes: low bits ignored, the spare field held.
    access(1'h1, CTL_OFF, 32'h0);
    access(1'h0, CTL_OFF, 32'h0);
    check_pins();
    access(1'h1, CTL_OFF, 32'hffffffff);
    access(1'h0, CTL_OFF, 32'h0);
    check_pins();
    // Random words under random board kinds, each written then read back.
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      db_kind <= 3'(rnd() % 5);
      access(1'h1, CTL_OFF, rnd());
      access(1'h0, CTL_OFF, 32'h0);
      check_pins();
    end
    // Holes in the map refuse both directions.
    foreach (bad[i]) begin
      access(1'h1, bad[i], rnd());
      access(1'h0, bad[i], 32'h0);
    end
    // Block disabled: control word refused, enable still reachable.
    access(1'h1, BLK_EN_OFF, 32'h0);
    access(1'h1, CTL_OFF, ~to_bus(exp_w));
    access(1'h0, CTL_OFF, 32'h0);
    access(1'h0, BLK_EN_OFF, 32'h0);
    check_pins();
    access(1'h1, BLK_EN_OFF, 32'h80000000);
    access(1'h0, CTL_OFF, 32'h0);
    // Reset in mid-run restores every default.
    access(1'h1, CTL_OFF, 32'h0);
    @(posedge clk);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    exp_w  = CTL_RST;
    exp_en = 1'h1;
    nfall  = 0;
    access(1'h0, CTL_OFF, 32'h0);
    check_pins();
    finish_test();
  end
endmodule
